// ===== rtl/sgs_pkg.sv
// Package with register map, field layouts and constants for the supervision block
package sgs_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_DETMASK   = 8'h04;
	localparam logic [7:0] OFF_WDT_LIM   = 8'h08;
	localparam logic [7:0] OFF_WDT_CMD   = 8'h0C;
	localparam logic [7:0] OFF_RST_CFG   = 8'h10;
	localparam logic [7:0] OFF_RST_DLY   = 8'h14;
	localparam logic [7:0] OFF_PINSEL    = 8'h18;
	localparam logic [7:0] OFF_FPIN0     = 8'h1C;
	localparam logic [7:0] OFF_FPIN1     = 8'h20;
	localparam logic [7:0] OFF_RTC       = 8'h24;
	localparam logic [7:0] OFF_SUMMARY   = 8'h28;
	localparam logic [7:0] OFF_DETCNT    = 8'h2C;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h30;
	localparam logic [7:0] OFF_IRQ_CLR   = 8'h34;
	localparam logic [7:0] OFF_IRQ_EN    = 8'h38;
	localparam logic [7:0] OFF_STATUS    = 8'h3C;
	// Field positions
	localparam int CTRL_WDT_EN   = 0;
	localparam int CTRL_ONOFF_LO = 8;
	localparam int RST_PG_LO     = 0;
	localparam int RST_GPI_LO    = 8;
	localparam int RST_TIME_EN   = 16;
	localparam int FP_RAIL_LO    = 0;
	localparam int FP_GPI_LO     = 8;
	localparam int FP_POL        = 16;
	localparam int FP_AND        = 17;
	localparam int IRQ_WDT       = 0;
	localparam int IRQ_FAULT     = 1;
	localparam int IRQ_LOGFULL   = 2;
	// Reset values and the watchdog command key
	localparam logic [31:0] RST_DETMASK = 32'hFFFFFFFF;
	localparam logic [31:0] RST_WDT_LIM = 32'h000F4240;
	localparam logic [31:0] RST_RST_DLY = 32'h00004E20;
	localparam logic [31:0] WDT_KEY     = 32'h00000001;
	// Detailed log capacity
	localparam int DETAIL_CAP = 26;
	// Run-time clock tick, 1 ms at 20 MHz
	localparam int CLK_HZ     = 20000000;
	localparam int RTC_TICK_MS = 1;
	localparam int RTC_TICK_CYC = CLK_HZ / 1000 * RTC_TICK_MS;
	// Fault code of the watchdog timeout in the common group
	localparam logic [7:0] CODE_WDT = 8'h00;

	typedef struct packed {
		logic [7:0]  code;
		logic [31:0] stamp;
	} sgs_log_s;

	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} sgs_wb_req_s;
endpackage

// ===== rtl/sgs_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module sgs_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] out_r;
	// Change accepted only when stages two and three agree
	wire  [W-1:0] agree_w = ~(s2_r ^ s3_r);

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					s1_r[g]  <= 1'b0;
					s2_r[g]  <= 1'b0;
					s3_r[g]  <= 1'b0;
					out_r[g] <= 1'b0;
				end else if (ce_i) begin
					s1_r[g] <= async_i[g];
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					if (agree_w[g]) begin
						out_r[g] <= s3_r[g];
					end
				end
			end
		end
	endgenerate

	assign sync_o = out_r;
endmodule // sgs_sync

// ===== rtl/sgs_fault_pin.sv
// One fault-influenced output pin combiner
`timescale 1ns/1ns
module sgs_fault_pin #(
	parameter int RAILS = 8,
	parameter int GPIS  = 8
) (
	input  wire logic             clk_sys_i,
	input  wire logic             reset_i,
	input  wire logic             ce_i,
	input  wire logic [31:0]      cfg_i,
	input  wire logic [RAILS-1:0] rail_fault_i,
	input  wire logic [GPIS-1:0]  gpi_i,
	output logic                  pin_o
);
	wire [RAILS-1:0] rail_sel_w = cfg_i[sgs_pkg::FP_RAIL_LO +: RAILS];
	wire [GPIS-1:0]  gpi_sel_w  = cfg_i[sgs_pkg::FP_GPI_LO +: GPIS];
	wire             any_fault_w = |(rail_fault_i & rail_sel_w);
	wire             gpi_and_w   = &(gpi_i | ~gpi_sel_w);
	wire             gpi_or_w    = |(gpi_i & gpi_sel_w);
	// AND mode needs all selected inputs high; OR mode any
	wire             gpi_term_w  = cfg_i[sgs_pkg::FP_AND] ? gpi_and_w : gpi_or_w;
	wire             raw_w       = any_fault_w | ((|gpi_sel_w) & gpi_term_w);
	logic            pin_r;

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			pin_r <= 1'b0;
		end else if (ce_i) begin
			pin_r <= raw_w ^ cfg_i[sgs_pkg::FP_POL];
		end
	end

	assign pin_o = pin_r;
endmodule // sgs_fault_pin

// ===== rtl/sgs_top.sv
// Global supervision block: fault logging, system reset, watchdog, pin states, fault pins, run-time clock
`timescale 1ns/1ns
module sgs_top #(
	parameter int RAILS    = 8,
	parameter int GPIS     = 8,
	parameter int FPINS    = 2,
	parameter int SEL_PINS = 3,
	parameter int RTC_TICK = sgs_pkg::RTC_TICK_CYC
) (
	input  wire logic                clk_sys_i,
	input  wire logic                reset_i,
	input  wire logic                ce_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic                wb_we_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                watchdog_kick_input_i,
	input  wire logic [GPIS-1:0]     general_input_pin_i,
	input  wire logic [RAILS-1:0]    rail_pg_i,
	input  wire logic [RAILS-1:0]    rail_fault_i,
	output logic                     sys_reset_o,
	output logic [RAILS-1:0]         rail_on_o,
	output logic [FPINS-1:0]         fault_pin_o,
	output logic                     log_wr_o,
	output logic                     log_detail_o,
	output sgs_pkg::sgs_log_s        log_entry_o,
	output logic                     irq_o
);
	if (RAILS < 1 || RAILS > 8 || GPIS < SEL_PINS || GPIS > 8 || SEL_PINS > 3 || FPINS < 1 || FPINS > 2) begin : g_bad_param
		$error("sgs_top: unsupported parameters");
	end

	localparam int EVW = RAILS + 1;

	// Synchronised pins
	logic [GPIS-1:0]  gpi_w;
	logic [RAILS-1:0] pg_w;
	logic [RAILS-1:0] flt_w;
	logic             kick_w;
	sgs_sync #(.W(GPIS + 2*RAILS + 1)) u_sync (
		.clk_sys_i (clk_sys_i),
		.reset_i   (reset_i),
		.ce_i      (ce_i),
		.async_i   ({watchdog_kick_input_i, rail_fault_i, rail_pg_i, general_input_pin_i}),
		.sync_o    ({kick_w, flt_w, pg_w, gpi_w})
	);

	// Registers
	logic [31:0] ctrl_r, detmask_r, wdt_lim_r, rst_cfg_r, rst_dly_r, pinsel_r, rtc_r;
	logic [31:0] fpin_r [FPINS];
	logic [31:0] summary_r;
	logic [4:0]  detcnt_r;
	logic [2:0]  irq_stat_r, irq_en_r;
	logic [31:0] wdt_cnt_r, rst_cnt_r, tick_r;
	logic        kick_d_r, ack_r, sysrst_r, log_wr_r, log_det_r, irq_r;
	logic [31:0] dat_r;
	logic [RAILS-1:0] flt_d_r, rail_on_r;
	sgs_pkg::sgs_log_s entry_r;

	// Bus decode
	wire        req_w   = wb_cyc_i & wb_stb_i & ~ack_r;
	wire        wr_w    = req_w & wb_we_i;
	wire [31:0] bmask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire        wr_ctrl_w = wr_w && wb_adr_i == sgs_pkg::OFF_CTRL;
	wire        wr_mask_w = wr_w && wb_adr_i == sgs_pkg::OFF_DETMASK;
	wire        wr_lim_w  = wr_w && wb_adr_i == sgs_pkg::OFF_WDT_LIM;
	wire        wr_kcmd_w = wr_w && wb_adr_i == sgs_pkg::OFF_WDT_CMD && wb_dat_i == sgs_pkg::WDT_KEY;
	wire        wr_rcfg_w = wr_w && wb_adr_i == sgs_pkg::OFF_RST_CFG;
	wire        wr_rdly_w = wr_w && wb_adr_i == sgs_pkg::OFF_RST_DLY;
	wire        wr_psel_w = wr_w && wb_adr_i == sgs_pkg::OFF_PINSEL;
	wire        wr_fp0_w  = wr_w && wb_adr_i == sgs_pkg::OFF_FPIN0;
	wire        wr_fp1_w  = wr_w && wb_adr_i == sgs_pkg::OFF_FPIN1;
	wire        wr_rtc_w  = wr_w && wb_adr_i == sgs_pkg::OFF_RTC;
	wire        wr_iclr_w = wr_w && wb_adr_i == sgs_pkg::OFF_IRQ_CLR;
	wire        wr_ien_w  = wr_w && wb_adr_i == sgs_pkg::OFF_IRQ_EN;
	wire        wr_sum_w  = wr_w && wb_adr_i == sgs_pkg::OFF_SUMMARY;

	// Watchdog
	wire kick_tog_w = kick_w ^ kick_d_r;
	wire wdt_en_w   = ctrl_r[sgs_pkg::CTRL_WDT_EN];
	wire wdt_hit_w  = wdt_en_w && wdt_cnt_r == wdt_lim_r;
	wire wdt_rst_w  = kick_tog_w | wr_kcmd_w | ~wdt_en_w;

	// Fault events: bit 0 watchdog, bits 1.. rising rail faults
	wire [EVW-1:0] ev_w    = {flt_w & ~flt_d_r, wdt_hit_w};
	wire [EVW-1:0] ev_en_w = ev_w & detmask_r[EVW-1:0];
	logic [3:0] ev_idx_w;
	always_comb begin
		ev_idx_w = 4'h0;
		for (int i = EVW - 1; i >= 0; i--) begin
			if (ev_w[i]) begin
				ev_idx_w = 4'(i);
			end
		end
	end
	wire any_ev_w  = |ev_w;
	wire room_w    = detcnt_r < 5'(sgs_pkg::DETAIL_CAP);
	wire det_go_w  = any_ev_w && ev_en_w[ev_idx_w] && room_w;
	wire full_ev_w = any_ev_w && ev_en_w[ev_idx_w] && !room_w;

	// System reset release conditions
	wire [RAILS-1:0] pg_sel_w  = rst_cfg_r[sgs_pkg::RST_PG_LO +: RAILS];
	wire [GPIS-1:0]  gpi_sel_w = rst_cfg_r[sgs_pkg::RST_GPI_LO +: GPIS];
	wire pg_ok_w   = &(pg_w | ~pg_sel_w);
	wire gpi_ok_w  = &(gpi_w | ~gpi_sel_w);
	wire time_en_w = rst_cfg_r[sgs_pkg::RST_TIME_EN];
	wire cond_ok_w = pg_ok_w & gpi_ok_w;
	wire time_ok_w = ~time_en_w | (rst_cnt_r >= rst_dly_r);

	// Pin selected rail states
	wire [RAILS-1:0] use_pin_w = ctrl_r[sgs_pkg::CTRL_ONOFF_LO +: RAILS];
	logic [RAILS-1:0] pin_on_w;
	genvar g;
	generate
		for (g = 0; g < RAILS; g++) begin : g_rail
			wire [2:0] sel_w = pinsel_r[4*g +: 3];
			// Each rail picks one of the state pins by index
			assign pin_on_w[g] = (sel_w < 3'(SEL_PINS)) ? gpi_w[sel_w] : 1'b0;
		end
		for (g = 0; g < FPINS; g++) begin : g_fpin
			sgs_fault_pin #(.RAILS(RAILS), .GPIS(GPIS)) u_fp (
				.clk_sys_i    (clk_sys_i),
				.reset_i      (reset_i),
				.ce_i         (ce_i),
				.cfg_i        (fpin_r[g]),
				.rail_fault_i (flt_w),
				.gpi_i        (gpi_w),
				.pin_o        (fault_pin_o[g])
			);
		end
	endgenerate

	wire [2:0] irq_set_w = {full_ev_w, any_ev_w, wdt_hit_w};

	// Read mux
	logic [31:0] rd_w;
	always_comb begin
		case (wb_adr_i)
			sgs_pkg::OFF_CTRL:     rd_w = ctrl_r;
			sgs_pkg::OFF_DETMASK:  rd_w = detmask_r;
			sgs_pkg::OFF_WDT_LIM:  rd_w = wdt_lim_r;
			sgs_pkg::OFF_RST_CFG:  rd_w = rst_cfg_r;
			sgs_pkg::OFF_RST_DLY:  rd_w = rst_dly_r;
			sgs_pkg::OFF_PINSEL:   rd_w = pinsel_r;
			sgs_pkg::OFF_FPIN0:    rd_w = fpin_r[0];
			sgs_pkg::OFF_FPIN1:    rd_w = (FPINS > 1) ? fpin_r[FPINS-1] : 32'h00000000;
			sgs_pkg::OFF_RTC:      rd_w = rtc_r;
			sgs_pkg::OFF_SUMMARY:  rd_w = summary_r;
			sgs_pkg::OFF_DETCNT:   rd_w = {27'h0000000, detcnt_r};
			sgs_pkg::OFF_IRQ_STAT: rd_w = {29'h00000000, irq_stat_r};
			sgs_pkg::OFF_IRQ_EN:   rd_w = {29'h00000000, irq_en_r};
			sgs_pkg::OFF_STATUS:   rd_w = 32'({sysrst_r, rail_on_r});
			default:               rd_w = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else if (ce_i) begin
			ack_r <= req_w;
			dat_r <= req_w ? rd_w : 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			ctrl_r    <= 32'h00000000;
			detmask_r <= sgs_pkg::RST_DETMASK;
			wdt_lim_r <= sgs_pkg::RST_WDT_LIM;
			rst_cfg_r <= 32'h00000000;
			rst_dly_r <= sgs_pkg::RST_RST_DLY;
			pinsel_r  <= 32'h00000000;
			irq_en_r  <= 3'h0;
		end else if (ce_i) begin
			if (wr_ctrl_w) ctrl_r <= (ctrl_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_mask_w) detmask_r <= (detmask_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_lim_w)  wdt_lim_r <= (wdt_lim_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_rcfg_w) rst_cfg_r <= (rst_cfg_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_rdly_w) rst_dly_r <= (rst_dly_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_psel_w) pinsel_r <= (pinsel_r & ~bmask_w) | (wb_dat_i & bmask_w);
			if (wr_ien_w)  irq_en_r <= wb_dat_i[2:0];
		end
	end

	generate
		for (g = 0; g < FPINS; g++) begin : g_fpreg
			wire we_w = (g == 0) ? wr_fp0_w : wr_fp1_w;
			always_ff @(posedge clk_sys_i) begin
				if (reset_i) begin
					fpin_r[g] <= 32'h00000000;
				end else if (ce_i && we_w) begin
					fpin_r[g] <= (fpin_r[g] & ~bmask_w) | (wb_dat_i & bmask_w);
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			tick_r <= 32'h00000000;
			rtc_r  <= 32'h00000000;
		end else if (ce_i) begin
			tick_r <= (tick_r == 32'(RTC_TICK - 1)) ? 32'h00000000 : tick_r + 32'h00000001;
			if (wr_rtc_w) begin
				rtc_r <= wb_dat_i;
			end else if (tick_r == 32'(RTC_TICK - 1)) begin
				rtc_r <= rtc_r + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			kick_d_r  <= 1'b0;
			wdt_cnt_r <= 32'h00000000;
			flt_d_r   <= '0;
		end else if (ce_i) begin
			kick_d_r  <= kick_w;
			flt_d_r   <= flt_w;
			wdt_cnt_r <= (wdt_rst_w || wdt_hit_w) ? 32'h00000000 : wdt_cnt_r + 32'h00000001;
		end
	end

	// Logging; summary write of one clears its bits, new events win
	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			summary_r <= 32'h00000000;
			detcnt_r  <= 5'h00;
			log_wr_r  <= 1'b0;
			log_det_r <= 1'b0;
			entry_r   <= '0;
		end else if (ce_i) begin
			summary_r[EVW-1:0] <= (wr_sum_w ? summary_r[EVW-1:0] & ~wb_dat_i[EVW-1:0]
			                                : summary_r[EVW-1:0]) | ev_w;
			log_wr_r  <= any_ev_w;
			log_det_r <= det_go_w;
			if (det_go_w) detcnt_r <= detcnt_r + 5'h01;
			if (any_ev_w) entry_r <= '{code: 8'(ev_idx_w) + sgs_pkg::CODE_WDT, stamp: rtc_r};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (reset_i) begin
			rst_cnt_r <= 32'h00000000;
			sysrst_r  <= 1'b1;
			rail_on_r <= '0;
			irq_stat_r <= 3'h0;
			irq_r     <= 1'b0;
		end else if (ce_i) begin
			// Timer only runs once the level conditions hold, restarts if they drop
			rst_cnt_r <= !cond_ok_w ? 32'h00000000 : (time_ok_w ? rst_cnt_r : rst_cnt_r + 32'h00000001);
			sysrst_r  <= !(cond_ok_w && time_ok_w);
			rail_on_r <= (use_pin_w & pin_on_w) | (~use_pin_w & rail_pg_on(rail_on_r));
			irq_stat_r <= (irq_stat_r & ~(wr_iclr_w ? wb_dat_i[2:0] : 3'h0)) | irq_set_w;
			irq_r     <= |(irq_stat_r & irq_en_r);
		end
	end

	// Rails not under pin control hold their state; other sequencer logic owns them
	function automatic logic [RAILS-1:0] rail_pg_on(input logic [RAILS-1:0] cur);
		rail_pg_on = cur;
	endfunction

	assign wb_ack_o     = ack_r;
	assign wb_dat_o     = dat_r;
	assign sys_reset_o  = sysrst_r;
	assign rail_on_o    = rail_on_r;
	assign log_wr_o     = log_wr_r;
	assign log_detail_o = log_det_r;
	assign log_entry_o  = entry_r;
	assign irq_o        = irq_r;

	a_detail_masked: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && any_ev_w && !ev_en_w[ev_idx_w] |=> !log_detail_o)
		else $error("detail entry written for masked fault");
	a_summary_all: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && any_ev_w |=> log_wr_o)
		else $error("fault missing from summary log");
	a_cap_limit: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		detcnt_r <= 5'(sgs_pkg::DETAIL_CAP))
		else $error("detail log over capacity");
	a_wdt_restart: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && wr_kcmd_w |=> wdt_cnt_r == 32'h00000000)
		else $error("watchdog not restarted by command");
	a_reset_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && !cond_ok_w |=> sys_reset_o)
		else $error("system reset released early");
	a_reset_release: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && cond_ok_w && time_ok_w |=> !sys_reset_o)
		else $error("system reset not released");
	a_rtc_set: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && wr_rtc_w |=> rtc_r == $past(wb_dat_i))
		else $error("run-time clock not set");
	a_wdt_log: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ce_i && wdt_hit_w |=> log_wr_o && log_entry_o.code == sgs_pkg::CODE_WDT)
		else $error("watchdog timeout not logged");
endmodule // sgs_top

// ===== bench/sgs_host.sv
// Host controller model: classic Wishbone master for the supervision registers
`timescale 1ns/1ns
module sgs_host (
	input  wire logic            clk_sys_i,
	output sgs_pkg::sgs_wb_req_s req_o,
	input  wire logic [31:0]     dat_i,
	input  wire logic            ack_i
);
	initial begin
		req_o = '0;
	end

	// Request held until ack; the next call starts a cycle later, so the bus idles in between
	// No wait limit here: a missing ack hangs and the bench timeout ends the run
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys_i);
		req_o <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
		do begin
			@(posedge clk_sys_i);
		end while (ack_i !== 1'b1);
		q = dat_i;
		req_o <= '0;
	endtask
endmodule // sgs_host

// ===== bench/tb_sgs_top.sv
// Self-checking testbench for the global supervision block
`timescale 1ns/1ns
module tb_sgs_top;
	logic                 clk_sys_i;
	logic                 reset_i;
	logic                 kick;
	logic [7:0]           general_input_pin;
	logic [7:0]           pg;
	logic [7:0]           flt;
	sgs_pkg::sgs_wb_req_s req;
	logic [31:0]          wb_dat_o;
	logic                 wb_ack_o;
	logic                 sys_reset_o;
	logic [7:0]           rail_on_o;
	logic [1:0]           fault_pin_o;
	logic                 log_wr_o;
	logic                 log_detail_o;
	sgs_pkg::sgs_log_s    log_entry_o;
	logic                 irq_o;
	int                   compares;
	int                   miscompares;
	int                   det_cnt;
	int                   wdt_cnt;

	sgs_top #(.RTC_TICK(4)) u_sgs_top (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
		.wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_sel_i(req.sel), .wb_we_i(req.we),
		.wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.watchdog_kick_input_i(kick), .general_input_pin_i(general_input_pin), .rail_pg_i(pg), .rail_fault_i(flt),
		.sys_reset_o(sys_reset_o), .rail_on_o(rail_on_o), .fault_pin_o(fault_pin_o), .log_wr_o(log_wr_o),
		.log_detail_o(log_detail_o), .log_entry_o(log_entry_o), .irq_o(irq_o));

	sgs_host u_sgs_host (.clk_sys_i(clk_sys_i), .req_o(req), .dat_i(wb_dat_o), .ack_i(wb_ack_o));

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	task automatic stop_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp1(input string what, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_sgs_host.access(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		u_sgs_host.access(1'b0, a, 32'h00000000, q);
		cmp32(what, exp, q);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask

	// Outputs are looked at on the falling edge, well clear of the launch edge
	task automatic settle(input int n);
		cyc(n);
		@(negedge clk_sys_i);
	endtask

	task automatic wait_log(input int lim, output logic [7:0] code, output logic det, output logic [31:0] st);
		int n;
		n = 0;
		code = 8'hEE;
		det = 1'bx;
		st = 32'h00000000;
		while (n < lim) begin
			@(negedge clk_sys_i);
			n++;
			if (log_wr_o === 1'b1) begin
				code = log_entry_o.code;
				det = log_detail_o;
				st = log_entry_o.stamp;
				n = lim;
			end
		end
	endtask

	always @(negedge clk_sys_i) begin
		if (log_wr_o === 1'b1 && log_detail_o === 1'b1) det_cnt++;
		if (log_wr_o === 1'b1 && log_entry_o.code === sgs_pkg::CODE_WDT) wdt_cnt++;
	end

	// Scenarios need about 1000 cycles; the ceiling leaves ample margin
	initial begin
		int n;
		n = 0;
		forever begin
			@(posedge clk_sys_i);
			n++;
			if (n == 6000) begin
				miscompares++;
				stop_test();
			end
		end
	end

	initial begin
		logic [7:0]  code;
		logic        det;
		logic [31:0] st;
		reset_i = 1'b1;
		kick = 1'b0;
		general_input_pin = 8'h00;
		pg = 8'h00;
		flt = 8'h00;
		settle(11);
		cmp1("sys_reset_o in reset", 1'b1, sys_reset_o);
		cyc(1);
		reset_i <= 1'b0;
		rd_chk("detail mask reset", sgs_pkg::OFF_DETMASK, sgs_pkg::RST_DETMASK);
		rd_chk("watchdog limit reset", sgs_pkg::OFF_WDT_LIM, sgs_pkg::RST_WDT_LIM);
		rd_chk("reset delay reset", sgs_pkg::OFF_RST_DLY, sgs_pkg::RST_RST_DLY);
		rd_chk("unmapped read", 8'h40, 32'h00000000);
		// Mask and clock set, then a masked and an unmasked rail fault
		wr(sgs_pkg::OFF_DETMASK, 32'h00000004);
		wr(sgs_pkg::OFF_RTC, 32'h00001000);
		flt[0] <= 1'b1;
		wait_log(20, code, det, st);
		cmp32("masked fault code", 32'h00000001, {24'h000000, code});
		cmp1("masked fault detail", 1'b0, det);
		cmp1("stamp after clock set", 1'b1, st >= 32'h00001000 && st < 32'h00001010);
		cyc(1);
		flt[1] <= 1'b1;
		wait_log(20, code, det, st);
		cmp32("enabled fault code", 32'h00000002, {24'h000000, code});
		cmp1("enabled fault detail", 1'b1, det);
		rd_chk("summary after two faults", sgs_pkg::OFF_SUMMARY, 32'h00000006);
		rd_chk("detail count one", sgs_pkg::OFF_DETCNT, 32'h00000001);
		flt <= 8'h00;
		// Watchdog kept alive by pin toggles, then by commands, then left to expire
		wr(sgs_pkg::OFF_DETMASK, 32'h00000000);
		wr(sgs_pkg::OFF_WDT_LIM, 32'h00000028);
		wr(sgs_pkg::OFF_CTRL, 32'h00000001);
		repeat (8) begin
			cyc(15);
			kick <= ~kick;
		end
		repeat (8) begin
			cyc(12);
			wr(sgs_pkg::OFF_WDT_CMD, sgs_pkg::WDT_KEY);
		end
		cmp32("timeouts while kicked", 32'h00000000, wdt_cnt);
		wait_log(80, code, det, st);
		cmp32("watchdog fault code", {24'h000000, sgs_pkg::CODE_WDT}, {24'h000000, code});
		cmp1("watchdog detail masked", 1'b0, det);
		cmp1("irq masked", 1'b0, irq_o);
		wr(sgs_pkg::OFF_IRQ_EN, 32'h00000001);
		settle(2);
		cmp1("irq enabled", 1'b1, irq_o);
		wr(sgs_pkg::OFF_CTRL, 32'h00000000);
		wr(sgs_pkg::OFF_IRQ_CLR, 32'h00000001);
		settle(2);
		cmp1("irq cleared", 1'b0, irq_o);
		// System reset on rail 0 power-good, input 0 and a 20 cycle hold
		wr(sgs_pkg::OFF_RST_DLY, 32'h00000014);
		wr(sgs_pkg::OFF_RST_CFG, 32'h00010101);
		settle(8);
		cmp1("reset while unpowered", 1'b1, sys_reset_o);
		cyc(1);
		pg[0] <= 1'b1;
		general_input_pin[0] <= 1'b1;
		settle(15);
		cmp1("reset during hold", 1'b1, sys_reset_o);
		settle(20);
		cmp1("reset released", 1'b0, sys_reset_o);
		cyc(1);
		general_input_pin[0] <= 1'b0;
		settle(8);
		cmp1("reset on input drop", 1'b1, sys_reset_o);
		// Rail 0 follows input pin 1; rail 1 is not pin controlled
		wr(sgs_pkg::OFF_PINSEL, 32'h00000001);
		wr(sgs_pkg::OFF_CTRL, 32'h00000100);
		general_input_pin[1] <= 1'b1;
		settle(8);
		cmp32("rails on by pin", 32'h00000001, {24'h000000, rail_on_o});
		cyc(1);
		general_input_pin[1] <= 1'b0;
		settle(8);
		cmp32("rails off by pin", 32'h00000000, {24'h000000, rail_on_o});
		// Fault pins on rail 3, second one inverted, then an input term
		wr(sgs_pkg::OFF_FPIN0, 32'h00000008);
		wr(sgs_pkg::OFF_FPIN1, 32'h00010008);
		settle(8);
		cmp32("fault pins idle", 32'h00000002, {30'h00000000, fault_pin_o});
		cyc(1);
		flt[3] <= 1'b1;
		settle(8);
		cmp32("fault pins on fault", 32'h00000001, {30'h00000000, fault_pin_o});
		cyc(1);
		flt[3] <= 1'b0;
		general_input_pin[1] <= 1'b1;
		wr(sgs_pkg::OFF_FPIN0, 32'h00000208);
		settle(8);
		cmp1("fault pin by input", 1'b1, fault_pin_o[0]);
		// AND of inputs 0 and 1 while input 0 is low
		wr(sgs_pkg::OFF_FPIN0, 32'h00020308);
		settle(4);
		cmp1("fault pin and mode", 1'b0, fault_pin_o[0]);
		// Detail log filled past its capacity
		wr(sgs_pkg::OFF_DETMASK, 32'hFFFFFFFF);
		repeat (30) begin
			flt[7] <= 1'b1;
			cyc(8);
			flt[7] <= 1'b0;
			cyc(8);
		end
		cmp32("detail writes", sgs_pkg::DETAIL_CAP, det_cnt);
		rd_chk("detail count full", sgs_pkg::OFF_DETCNT, sgs_pkg::DETAIL_CAP);
		rd_chk("status with log full", sgs_pkg::OFF_IRQ_STAT, 32'h00000006);
		rd_chk("summary of all faults", sgs_pkg::OFF_SUMMARY, 32'h00000117);
		wr(sgs_pkg::OFF_SUMMARY, 32'h00000100);
		rd_chk("summary after clear", sgs_pkg::OFF_SUMMARY, 32'h00000017);
		rd_chk("status reset and rails", sgs_pkg::OFF_STATUS, 32'h00000101);
		stop_test();
	end
endmodule // tb_sgs_top
